// File: common/cle_map.vh
// Constants for the console line editor
`ifndef CLE_MAP_VH
`define CLE_MAP_VH

// Line length limit in counted characters
`define CLE_MAX_LEN 7'h50

// Control and printable characters
`define CLE_CH_ABORT  8'h03
`define CLE_CH_BS     8'h08
`define CLE_CH_TAB    8'h09
`define CLE_CH_LF     8'h0A
`define CLE_CH_CR     8'h0D
`define CLE_CH_DISC   8'h0F
`define CLE_CH_RESUME 8'h11
`define CLE_CH_RETYPE 8'h12
`define CLE_CH_HOLD   8'h13
`define CLE_CH_LDEL   8'h15
`define CLE_CH_SP     8'h20
`define CLE_CH_SLASH  8'h2F
`define CLE_CH_UNK    8'h3F
`define CLE_CH_BSL    8'h5C
`define CLE_CH_CARET  8'h5E
`define CLE_CH_RUB    8'h7F
`define CLE_CH_PTOP   8'h7E

// Prompt text, three characters
`define CLE_PROMPT 24'h3E_3E3E

// Keyword table, ten characters each, space padded
`define CLE_KW_LEN 10
`define CLE_KW_0 "BOOT      "
`define CLE_KW_1 "CONTINUE  "
`define CLE_KW_2 "DEPOSIT   "
`define CLE_KW_3 "EXAMINE   "
`define CLE_KW_4 "HALT      "
`define CLE_KW_5 "INITIALIZE"
`define CLE_KW_6 "START     "
`define CLE_KW_7 "TEST      "

// Address space codes
`define CLE_SP_PHYS 3'h0
`define CLE_SP_VIRT 3'h1
`define CLE_SP_GPR  3'h3
`define CLE_SP_IPR  3'h4
`define CLE_SP_PSL  3'h5

// Argument token kinds
`define CLE_AM_HEX  2'h0
`define CLE_AM_REG  2'h1
`define CLE_AM_QUAL 2'h2

`endif

// File: src/cle_console_line_editor.v
// Console command-line editor, echo control and command parser
// Overview of operation
// - Carriage return ends the line; nothing is parsed before it.
// - An empty line is a null command; only a fresh prompt follows.
// - Carriage return echoes as carriage return then line feed.
// - Rubout removes the last typed character from the buffer.
// - Hard-copy rubouts echo deleted characters framed by backslashes.
// - Video rubout erases the character and backs the cursor up.
// - Rubouts on an empty line or past its start are ignored.
// - Line delete echoes caret U and return, then clears the buffer.
// - Hold character stops all output until resume; not echoed.
// - Resume character restarts held output; not echoed.
// - Retype echoes return, line feed and the whole current line.
// - Abort echoes caret C and return, aborts, drops the partial line.
// - Discard character toggles output discard; caret O echoed on entry only.
// - Discard ends on error, prompt, console entry, break or abort.
// - Lines over eighty counted characters are reported as errors.
// - Count excludes rubouts, their victims and the final return.
// - Any keyword prefix naming exactly one command is accepted.
// - Space runs collapse and typed tabs are ignored; leading and trailing spaces dropped.
// - Numbers are hexadecimal; register name numerals are decimal.
// - Hex letters and keywords match in either case.
// - Address space persists between commands; starts as physical.
`timescale 1ns/100ps
`include "cle_map.vh"
`default_nettype none

module cle_console_line_editor
#(
   parameter [6:0] MAX_LEN = `CLE_MAX_LEN
)
(
   // Clock and reset
   input  wire        clock,
   input  wire        rst,
   // Terminal receive
   input  wire        rx_valid,
   input  wire [7:0]  rx_data,
   output wire        rx_ready,
   // Terminal transmit
   output wire        tx_valid,
   output wire [7:0]  tx_data,
   input  wire        tx_ready,
   // Terminal type and break pins
   input  wire        video_pin,
   input  wire        break_pin,
   // Command executor
   input  wire        exec_done,
   input  wire        exec_error,
   input  wire        console_enter,
   output reg         cmd_valid,
   output reg  [2:0]  cmd_code,
   output reg  [31:0] cmd_arg,
   output reg         cmd_has_arg,
   output reg  [2:0]  cmd_space,
   output reg         cmd_error,
   output reg         cmd_abort,
   // Output state
   output wire        output_hold,
   output wire        output_discard
);

   localparam [2:0] S_IDLE   = 3'h0;
   localparam [2:0] S_EMIT   = 3'h1;
   localparam [2:0] S_RETYPE = 3'h2;
   localparam [2:0] S_PARSE  = 3'h3;
   localparam [2:0] S_FIN    = 3'h4;
   localparam [2:0] S_WAIT   = 3'h5;
   localparam [2:0] S_PROMPT = 3'h6;

   reg  [7:0]  mem [0:MAX_LEN-1];
   reg  [2:0]  st;
   reg  [2:0]  after;
   reg  [23:0] es;
   reg  [1:0]  en;
   reg         disc_after;
   reg         xoff;
   reg         discard;
   reg         in_rub;
   reg  [6:0]  cnt;
   reg  [6:0]  ri;
   reg  [6:0]  pi;
   reg         in_tok;
   reg  [1:0]  ntok;
   reg  [3:0]  tpos;
   reg  [7:0]  kmask;
   reg  [1:0]  amode;
   reg  [31:0] anum;
   reg         perr;
   reg         has_arg;
   reg  [2:0]  qspace;
   reg         video_s1;
   reg         video_s2;
   reg         brk_s1;
   reg         brk_s2;
   wire [6:0]  len;
   wire        take;
   wire [7:0]  c;
   wire [7:0]  pc;
   wire        ws;
   wire [4:0]  hv;
   wire [7:0]  del;
   wire [7:0]  km;

   // Upper-case fold
   function [7:0] upc;
      input [7:0] ch;
      begin
         upc = (ch >= 8'h61 && ch <= 8'h7A) ? ch - 8'h20 : ch;
      end
   endfunction

   // Hex digit value, bit 4 marks a valid digit
   function [4:0] hexv;
      input [7:0] u;
      begin
         if (u >= 8'h30 && u <= 8'h39)
            hexv = {1'b1, u[3:0]};
         else if (u >= 8'h41 && u <= 8'h46)
            hexv = {1'b1, u[3:0] + 4'h9};
         else
            hexv = 5'h00;
      end
   endfunction

   // Keyword character at a position
   function [7:0] kwc;
      input [2:0] k;
      input [3:0] p;
      reg [79:0] w;
      integer    sh;
      begin
         case (k)
            3'h0:    w = `CLE_KW_0;
            3'h1:    w = `CLE_KW_1;
            3'h2:    w = `CLE_KW_2;
            3'h3:    w = `CLE_KW_3;
            3'h4:    w = `CLE_KW_4;
            3'h5:    w = `CLE_KW_5;
            3'h6:    w = `CLE_KW_6;
            default: w = `CLE_KW_7;
         endcase
         sh = (p < `CLE_KW_LEN) ? (`CLE_KW_LEN - 1 - p) : 0;
         kwc = (p < `CLE_KW_LEN) ? w[8*sh +: 8] : 8'h00;
      end
   endfunction

   // Keywords whose character at a position matches
   function [7:0] kwmatch;
      input [7:0] u;
      input [3:0] p;
      reg [3:0] k;
      begin
         kwmatch = 8'h00;
         for (k = 4'h0; k < 4'h8; k = k + 4'h1)
            kwmatch[k[2:0]] = (kwc(k[2:0], p) == u);
      end
   endfunction

   // Load a short echo sequence
   task say;
      input [23:0] s;
      input [1:0]  n;
      input [2:0]  a;
      begin
         es <= s;
         en <= n;
         after <= a;
         st <= S_EMIT;
      end
   endtask

   assign len = (cnt > MAX_LEN) ? MAX_LEN : cnt;
   assign rx_ready = (st == S_IDLE) || (st == S_WAIT) || xoff;
   assign take = rx_valid && rx_ready;
   assign c = rx_data;
   assign tx_valid = (st == S_EMIT) && !xoff && !discard;
   assign tx_data = es[23:16];
   assign output_hold = xoff;
   assign output_discard = discard;
   assign pc = (pi < len) ? upc(mem[pi]) : `CLE_CH_SP;
   assign ws = (pc == `CLE_CH_SP) || (pc == `CLE_CH_TAB);
   assign hv = hexv(pc);
   assign km = kwmatch(pc, tpos);
   assign del = (cnt != 7'h00 && cnt <= MAX_LEN) ? mem[cnt - 7'h01] : `CLE_CH_UNK;

   // Pin synchronisers
   always @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         video_s1 <= 1'b0;
         video_s2 <= 1'b0;
         brk_s1 <= 1'b0;
         brk_s2 <= 1'b0;
      end
      else
      begin
         video_s1 <= video_pin;
         video_s2 <= video_s1;
         brk_s1 <= break_pin;
         brk_s2 <= brk_s1;
      end
   end

   // Line buffer
   always @(posedge clock)
   begin
      if (st == S_IDLE && take && c >= `CLE_CH_SP && c <= `CLE_CH_PTOP && cnt < MAX_LEN)
         mem[cnt] <= c;
   end

   // Editor, echo and parser
   always @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         st <= S_IDLE;
         after <= S_IDLE;
         es <= 24'h00_0000;
         en <= 2'h0;
         disc_after <= 1'b0;
         xoff <= 1'b0;
         discard <= 1'b0;
         in_rub <= 1'b0;
         cnt <= 7'h00;
         ri <= 7'h00;
         pi <= 7'h00;
         in_tok <= 1'b0;
         ntok <= 2'h0;
         tpos <= 4'h0;
         kmask <= 8'h00;
         amode <= `CLE_AM_HEX;
         anum <= 32'h0000_0000;
         perr <= 1'b0;
         has_arg <= 1'b0;
         qspace <= `CLE_SP_PHYS;
         cmd_valid <= 1'b0;
         cmd_code <= 3'h0;
         cmd_arg <= 32'h0000_0000;
         cmd_has_arg <= 1'b0;
         cmd_space <= `CLE_SP_PHYS;
         cmd_error <= 1'b0;
         cmd_abort <= 1'b0;
      end
      else
      begin
         cmd_valid <= 1'b0;
         cmd_abort <= 1'b0;
         if (exec_error || console_enter || brk_s2)
            discard <= 1'b0;
         if (take && c == `CLE_CH_HOLD)
            xoff <= 1'b1;
         if (take && c == `CLE_CH_RESUME)
            xoff <= 1'b0;
         case (st)
            S_IDLE, S_WAIT:
            begin
               if (take && c == `CLE_CH_ABORT)
               begin
                  cmd_abort <= 1'b1;
                  discard <= 1'b0;
                  cnt <= 7'h00;
                  in_rub <= 1'b0;
                  say({`CLE_CH_CARET, 8'h43, `CLE_CH_CR}, 2'h3, S_PROMPT);
               end
               else if (take && c == `CLE_CH_DISC)
               begin
                  if (discard)
                     discard <= 1'b0;
                  else
                  begin
                     disc_after <= 1'b1;
                     say({`CLE_CH_CARET, 8'h4F, 8'h00}, 2'h2, st);
                  end
               end
               else if (st == S_WAIT)
               begin
                  if (exec_done)
                     st <= S_PROMPT;
               end
               else if (take && c == `CLE_CH_CR)
               begin
                  in_rub <= 1'b0;
                  pi <= 7'h00;
                  in_tok <= 1'b0;
                  ntok <= 2'h0;
                  kmask <= 8'h00;
                  perr <= 1'b0;
                  has_arg <= 1'b0;
                  qspace <= cmd_space;
                  if (in_rub)
                     say({`CLE_CH_BSL, `CLE_CH_CR, `CLE_CH_LF}, 2'h3, S_PARSE);
                  else
                     say({`CLE_CH_CR, `CLE_CH_LF, 8'h00}, 2'h2, S_PARSE);
               end
               else if (take && c == `CLE_CH_RUB)
               begin
                  if (cnt != 7'h00)
                  begin
                     cnt <= cnt - 7'h01;
                     if (video_s2)
                        say({`CLE_CH_BS, `CLE_CH_SP, `CLE_CH_BS}, 2'h3, S_IDLE);
                     else if (!in_rub)
                        say({`CLE_CH_BSL, del, 8'h00}, 2'h2, S_IDLE);
                     else
                        say({del, 16'h0000}, 2'h1, S_IDLE);
                     in_rub <= !video_s2;
                  end
               end
               else if (take && c == `CLE_CH_LDEL)
               begin
                  cnt <= 7'h00;
                  in_rub <= 1'b0;
                  say({`CLE_CH_CARET, 8'h55, `CLE_CH_CR}, 2'h3, S_IDLE);
               end
               else if (take && c == `CLE_CH_RETYPE)
               begin
                  ri <= 7'h00;
                  in_rub <= 1'b0;
                  say({`CLE_CH_CR, `CLE_CH_LF, 8'h00}, 2'h2, S_RETYPE);
               end
               else if (take && c >= `CLE_CH_SP && c <= `CLE_CH_PTOP)
               begin
                  if (cnt != 7'h7F)
                     cnt <= cnt + 7'h01;
                  in_rub <= 1'b0;
                  if (in_rub)
                     say({`CLE_CH_BSL, c, 8'h00}, 2'h2, S_IDLE);
                  else
                     say({c, 16'h0000}, 2'h1, S_IDLE);
               end
            end
            S_EMIT:
            begin
               if (!xoff && (tx_ready || discard))
               begin
                  es <= {es[15:0], 8'h00};
                  en <= en - 2'h1;
                  if (en == 2'h1)
                  begin
                     st <= after;
                     if (disc_after)
                        discard <= 1'b1;
                     disc_after <= 1'b0;
                  end
               end
            end
            S_RETYPE:
            begin
               if (ri >= len)
                  st <= S_IDLE;
               else
               begin
                  ri <= ri + 7'h01;
                  say({mem[ri], 16'h0000}, 2'h1, S_RETYPE);
               end
            end
            S_PARSE:
            begin
               pi <= pi + 7'h01;
               if (pi >= len)
                  st <= S_FIN;
               if (ws)
               begin
                  if (in_tok)
                  begin
                     in_tok <= 1'b0;
                     if (ntok != 2'h3)
                        ntok <= ntok + 2'h1;
                     if (ntok != 2'h0 && amode == `CLE_AM_REG && tpos == 4'h1)
                        perr <= 1'b1;
                  end
               end
               else if (!in_tok)
               begin
                  in_tok <= 1'b1;
                  tpos <= 4'h1;
                  if (ntok == 2'h0)
                     kmask <= kwmatch(pc, 4'h0);
                  else if (pc == `CLE_CH_SLASH)
                     amode <= `CLE_AM_QUAL;
                  else if (pc == 8'h52)
                  begin
                     amode <= `CLE_AM_REG;
                     anum <= 32'h0000_0000;
                     has_arg <= 1'b1;
                     qspace <= `CLE_SP_GPR;
                  end
                  else
                  begin
                     amode <= `CLE_AM_HEX;
                     anum <= {28'h000_0000, hv[3:0]};
                     has_arg <= 1'b1;
                     if (!hv[4])
                        perr <= 1'b1;
                  end
               end
               else
               begin
                  if (tpos != 4'hF)
                     tpos <= tpos + 4'h1;
                  if (ntok == 2'h0)
                     kmask <= kmask & km;
                  else if (amode == `CLE_AM_QUAL)
                  begin
                     if (tpos == 4'h1)
                     begin
                        case (pc)
                           8'h50:   qspace <= `CLE_SP_PHYS;
                           8'h56:   qspace <= `CLE_SP_VIRT;
                           8'h47:   qspace <= `CLE_SP_GPR;
                           8'h49:   qspace <= `CLE_SP_IPR;
                           8'h4D:   qspace <= `CLE_SP_PSL;
                           default: qspace <= qspace;
                        endcase
                     end
                  end
                  else if (amode == `CLE_AM_REG)
                  begin
                     anum <= anum[31:0] * 32'h0000_000A + {28'h000_0000, pc[3:0]};
                     if (pc < 8'h30 || pc > 8'h39)
                        perr <= 1'b1;
                  end
                  else
                  begin
                     anum <= {anum[27:0], hv[3:0]};
                     if (!hv[4])
                        perr <= 1'b1;
                  end
               end
            end
            S_FIN:
            begin
               if (ntok == 2'h0 && cnt <= MAX_LEN)
                  st <= S_PROMPT;
               else
               begin
                  cmd_valid <= 1'b1;
                  cmd_code <= 3'h0;
                  if (kmask[1]) cmd_code <= 3'h1;
                  if (kmask[2]) cmd_code <= 3'h2;
                  if (kmask[3]) cmd_code <= 3'h3;
                  if (kmask[4]) cmd_code <= 3'h4;
                  if (kmask[5]) cmd_code <= 3'h5;
                  if (kmask[6]) cmd_code <= 3'h6;
                  if (kmask[7]) cmd_code <= 3'h7;
                  cmd_arg <= anum;
                  cmd_has_arg <= has_arg;
                  cmd_error <= perr || (cnt > MAX_LEN) ||
                     kmask == 8'h00 || (kmask & (kmask - 8'h01)) != 8'h00;
                  if (!perr && cnt <= MAX_LEN)
                     cmd_space <= qspace;
                  st <= S_WAIT;
               end
               cnt <= 7'h00;
            end
            S_PROMPT:
            begin
               discard <= 1'b0;
               say(`CLE_PROMPT, 2'h3, S_IDLE);
            end
            default:
               st <= S_IDLE;
         endcase
      end
   end

endmodule // cle_console_line_editor

`default_nettype wire

// File: verification/cle_console_line_editor_properties.sv
// Port checks for the console line editor
`timescale 1ns/100ps
`default_nettype none
module cle_console_line_editor_properties
#(
   parameter [6:0] MAX_LEN = 80
)
(
   // Clock and reset
   input wire logic       clock,
   input wire logic       rst,
   // Terminal
   input wire logic       rx_valid,
   input wire logic [7:0] rx_data,
   input wire logic       rx_ready,
   input wire logic       tx_valid,
   input wire logic [7:0] tx_data,
   input wire logic       tx_ready,
   // Cancel sources and results
   input wire logic       break_pin,
   input wire logic       exec_error,
   input wire logic       console_enter,
   input wire logic       cmd_valid,
   input wire logic [2:0] cmd_space,
   input wire logic       cmd_abort,
   input wire logic       output_hold,
   input wire logic       output_discard
);
   wire take;
   assign take = rx_valid && rx_ready;
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   property p_reset_state;
      $fell(rst) |-> !tx_valid && rx_ready && !output_hold && !output_discard && cmd_space == 3'h0;
   endproperty
   a_reset_state: assert property (p_reset_state) else $error("bad state after reset");
   property p_hold_quiet;
      output_hold |-> !tx_valid;
   endproperty
   a_hold_quiet: assert property (p_hold_quiet) else $error("output while held");
   property p_discard_quiet;
      output_discard |-> !tx_valid;
   endproperty
   a_discard_quiet: assert property (p_discard_quiet) else $error("output while discarding");
   property p_busy_refuse;
      tx_valid |-> !rx_ready;
   endproperty
   a_busy_refuse: assert property (p_busy_refuse) else $error("input taken during echo");
   property p_echo_stands;
      tx_valid && !tx_ready |=> tx_valid && $stable(tx_data);
   endproperty
   a_echo_stands: assert property (p_echo_stands) else $error("echo dropped early");
   property p_hold_set;
      take && rx_data == 8'h13 |=> output_hold;
   endproperty
   a_hold_set: assert property (p_hold_set) else $error("hold not set");
   property p_resume;
      take && rx_data == 8'h11 |=> !output_hold;
   endproperty
   a_resume: assert property (p_resume) else $error("hold not released");
   property p_abort;
      take && rx_data == 8'h03 && !output_hold |=> cmd_abort && !output_discard;
   endproperty
   a_abort: assert property (p_abort) else $error("abort not flagged");
   property p_cmd_pulse;
      cmd_valid |=> !cmd_valid [*2];
   endproperty
   a_cmd_pulse: assert property (p_cmd_pulse) else $error("command pulse too long");
   property p_cancel;
      output_discard && (exec_error || console_enter) |=> !output_discard;
   endproperty
   a_cancel: assert property (p_cancel) else $error("discard not cancelled");
   property p_break;
      break_pin [*3] |=> !output_discard;
   endproperty
   a_break: assert property (p_break) else $error("break kept discard");
endmodule // cle_console_line_editor_properties
bind cle_console_line_editor cle_console_line_editor_properties #(.MAX_LEN(MAX_LEN)) u_cle_props
(
   .clock(clock), .rst(rst), .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
   .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .break_pin(break_pin),
   .exec_error(exec_error), .console_enter(console_enter), .cmd_valid(cmd_valid),
   .cmd_space(cmd_space), .cmd_abort(cmd_abort), .output_hold(output_hold),
   .output_discard(output_discard)
);
`default_nettype wire

// File: verification/cle_term_model.sv
// Terminal model that types characters and collects the echo
`timescale 1ns/100ps
`default_nettype none
module cle_term_model
(
   // Clock
   input  wire logic       clock,
   // Typed characters
   output var  logic       rx_valid,
   output var  logic [7:0] rx_data,
   input  wire logic       rx_ready,
   // Echoed characters
   input  wire logic       tx_valid,
   input  wire logic [7:0] tx_data,
   output var  logic       tx_ready,
   // Terminal kind
   output wire logic       video_pin
);
   logic       video = 1'b0;
   logic       slow = 1'b0;
   logic       took = 1'b0;
   logic [7:0] got[$];
   assign video_pin = video;
   initial
   begin
      rx_valid = 1'b0;
      rx_data = 8'h00;
      tx_ready = 1'b1;
   end
   // Stalls the echo every other cycle when slow
   always @(negedge clock)
   begin
      tx_ready <= slow ? ~tx_ready : 1'b1;
   end
   always @(posedge clock)
   begin
      took <= rx_valid && rx_ready;
      if (tx_valid && tx_ready)
      begin
         got.push_back(tx_data);
      end
   end
   task automatic type_char(input logic [7:0] c);
      int n;
      n = 0;
      @(negedge clock);
      rx_valid <= 1'b1;
      rx_data <= c;
      do
      begin
         @(negedge clock);
         n++;
      end
      while (!took && n < 500);
      rx_valid <= 1'b0;
      rx_data <= ~c;
   endtask
endmodule // cle_term_model
`default_nettype wire

// File: verification/cle_console_line_editor_tb_top.sv
// Self-checking bench for the console line editor
`timescale 1ns/100ps
`default_nettype none
module cle_console_line_editor_tb_top;
   typedef struct {
      string       txt;
      bit          vid;
      string       echo;
      bit          cmd;
      logic [2:0]  code;
      logic [31:0] arg;
      logic        has;
      logic        err;
      logic [2:0]  sp;
   } cle_row_t;
   logic        clock = 1'b0;
   logic        rst = 1'b1;
   logic        break_pin = 1'b0;
   logic        exec_done = 1'b0;
   logic        exec_error = 1'b0;
   logic        console_enter = 1'b0;
   wire         rx_valid, rx_ready, tx_valid, tx_ready, video_pin;
   wire  [7:0]  rx_data, tx_data;
   wire         cmd_valid, cmd_has_arg, cmd_error, cmd_abort, output_hold, output_discard;
   wire  [2:0]  cmd_code, cmd_space;
   wire  [31:0] cmd_arg;
   int          fails = 0;
   int          tests_run = 0;
   int          cmd_n = 0;
   int          abort_n = 0;
   cle_row_t rows[13] = '{
      '{"e 10\015", 0, "e 10\015\012", 1, 3'h3, 32'h0000_0010, 1, 0, 3'h0},
      '{"  DEP  aB \015", 0, "  DEP  aB \015\012", 1, 3'h2, 32'h0000_00AB, 1, 0, 3'h0},
      '{"\015", 0, "\015\012", 0, 3'h0, 32'h0000_0000, 0, 0, 3'h0},
      '{"EXAMI;E\177\177NE\015", 0, "EXAMI;E\\E;\\NE\015\012", 1, 3'h3, 32'h0, 0, 0, 3'h0},
      '{"TX\177\015", 1, "TX\010 \010\015\012", 1, 3'h7, 32'h0, 0, 0, 3'h0},
      '{"\177H\015", 0, "H\015\012", 1, 3'h4, 32'h0, 0, 0, 3'h0},
      '{"S\025C 1\015", 0, "S^U\015C 1\015\012", 1, 3'h1, 32'h0000_0001, 1, 0, 3'h0},
      '{"I\022\015", 0, "I\015\012I\015\012", 1, 3'h5, 32'h0, 0, 0, 3'h0},
      '{"X 1\015", 0, "X 1\015\012", 1, 3'h0, 32'h0, 0, 1, 3'h0},
      '{"E /P 2\015", 0, "E /P 2\015\012", 1, 3'h3, 32'h0000_0002, 1, 0, 3'h0},
      '{"E R10\015", 0, "E R10\015\012", 1, 3'h3, 32'h0000_000A, 1, 0, 3'h3},
      '{"e f\015", 0, "e f\015\012", 1, 3'h3, 32'h0000_000F, 1, 0, 3'h3},
      '{"HX\177\015", 0, "HX\\X\\\015\012", 1, 3'h4, 32'h0, 0, 0, 3'h3}
   };
   always #20 clock = ~clock;
   always @(posedge clock)
   begin
      if (cmd_valid === 1'b1) cmd_n++;
      if (cmd_abort === 1'b1) abort_n++;
   end
   cle_console_line_editor u_cle_console_line_editor
   (
      .clock(clock), .rst(rst), .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
      .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .video_pin(video_pin),
      .break_pin(break_pin), .exec_done(exec_done), .exec_error(exec_error),
      .console_enter(console_enter), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
      .cmd_arg(cmd_arg), .cmd_has_arg(cmd_has_arg), .cmd_space(cmd_space),
      .cmd_error(cmd_error), .cmd_abort(cmd_abort), .output_hold(output_hold),
      .output_discard(output_discard)
   );
   cle_term_model u_cle_term_model
   (
      .clock(clock), .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
      .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .video_pin(video_pin)
   );
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic check_echo(input string exp);
      check(u_cle_term_model.got.size(), exp.len());
      for (int i = 0; i < exp.len() && i < u_cle_term_model.got.size(); i++)
      begin
         check(u_cle_term_model.got[i], exp[i]);
      end
      u_cle_term_model.got.delete();
   endtask
   task automatic type_str(input string s);
      foreach (s[i]) u_cle_term_model.type_char(s[i]);
   endtask
   // Waits until the echo has been quiet for a while
   task automatic drain;
      int q;
      int n;
      q = 0;
      n = 0;
      while (q < 12 && n < 3000)
      begin
         @(negedge clock);
         q = (tx_valid === 1'b0) ? q + 1 : 0;
         n++;
      end
   endtask
   task automatic run_row(input cle_row_t r, input bit slw);
      int b;
      int n;
      @(negedge clock);
      u_cle_term_model.video = r.vid;
      u_cle_term_model.slow = slw;
      repeat (4) @(negedge clock);
      b = cmd_n;
      n = 0;
      type_str(r.txt);
      if (r.cmd)
      begin
         while (cmd_n == b && n < 1000)
         begin
            @(negedge clock);
            n++;
         end
         check(cmd_code, r.code);
         check(cmd_error, r.err);
         if (!r.err) check(cmd_has_arg, r.has);
         if (!r.err && r.has) check(cmd_arg, r.arg);
         if (!r.err) check(cmd_space, r.sp);
         exec_done = 1'b1;
         @(negedge clock);
         exec_done = 1'b0;
      end
      drain;
      check(cmd_n, b + r.cmd);
      if (r.echo == "*") u_cle_term_model.got.delete();
      else check_echo({r.echo, ">>>"});
   endtask
   task automatic end_of_test;
      $display("Comparisons %0d, mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
      begin
         $display("Testbench passed");
      end
      else
      begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   initial
   begin
      #(40 * 80000);
      fails++;
      end_of_test;
   end
   initial
   begin
      cle_row_t r;
      int b;
      repeat (12) @(posedge clock);
      @(negedge clock);
      rst = 1'b0;
      foreach (rows[i]) run_row(rows[i], i[0]);
      // Eighty characters, eighty-one, and eighty-one less one rubout
      for (int k = 0; k < 3; k++)
      begin
         r = '{"E ", 0, "*", 1, 3'h3, 32'h0, 1, k == 1, 3'h3};
         repeat (78 + (k > 0)) r.txt = {r.txt, "0"};
         if (k == 2) r.txt = {r.txt, "\177"};
         r.txt = {r.txt, "\015"};
         run_row(r, 0);
      end
      type_str("\023H");
      check(output_hold, 1'b1);
      repeat (6) @(negedge clock);
      check(u_cle_term_model.got.size(), 0);
      type_str("\021");
      check(output_hold, 1'b0);
      drain;
      check_echo("H");
      type_str("\025");
      drain;
      check_echo("^U\015");
      type_str("\017");
      drain;
      check_echo("^O");
      check(output_discard, 1'b1);
      type_str("H\017");
      drain;
      check(output_discard, 1'b0);
      check_echo("");
      b = abort_n;
      type_str("\003");
      drain;
      check_echo("^C\015>>>");
      check(abort_n, b + 1);
      type_str("\022");
      drain;
      check_echo("\015\012");
      for (int k = 0; k < 4; k++)
      begin
         type_str("\017");
         drain;
         check(output_discard, 1'b1);
         exec_error = (k == 0);
         console_enter = (k == 1);
         break_pin = (k == 2);
         if (k == 3) type_str("\003");
         @(negedge clock);
         exec_error = 1'b0;
         console_enter = 1'b0;
         repeat (4) @(negedge clock);
         break_pin = 1'b0;
         check(output_discard, 1'b0);
         u_cle_term_model.got.delete();
      end
      // Reset in mid-line drops the partial line
      type_str("E 5");
      rst = 1'b1;
      repeat (2) @(negedge clock);
      check(cmd_space, 3'h0);
      check(tx_valid, 1'b0);
      rst = 1'b0;
      drain;
      u_cle_term_model.got.delete();
      run_row('{"E\015", 0, "E\015\012", 1, 3'h3, 32'h0, 0, 0, 3'h0}, 1);
      end_of_test;
   end
endmodule // cle_console_line_editor_tb_top
`default_nettype wire
